// >>> core/amht_pkg.sv
/*
  constants for the alert mask and processor-hot timer block: register
  offsets, field positions, reset values and timing figures.
  assumes a 10 MHz core clock and an 8-bit register address/data path.
*/
package amht_pkg;

  // register address and data widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_HOT_TIMER  = 8'h0f;
  localparam logic [7:0] OFS_STATUS_ONE = 8'h10;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h11;
  localparam logic [7:0] OFS_MASK_ONE   = 8'h12;
  localparam logic [7:0] OFS_MASK_TWO   = 8'h13;
  localparam logic [7:0] OFS_HOT_LIMIT  = 8'h1e;

  // reset values
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RST_LIMIT  = 8'h00;
  localparam logic [7:0] RST_TIMER  = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // status/mask one field positions
  localparam int unsigned B1_SUMMARY     = 7;  // second_status_summary
  localparam int unsigned B1_INPUT_ONE   = 6;  // input_one_or_diode_two
  localparam int unsigned B1_INPUT_TWO   = 5;  // input_two
  localparam int unsigned B1_SUPPLY      = 4;
  localparam int unsigned B1_REMOTE_ONE  = 3;  // remote_temp_one
  localparam int unsigned B1_ON_DIE      = 2;  // on_die_temp
  localparam int unsigned B1_COOLER_ONE  = 1;  // cooler_one_slow
  localparam int unsigned B1_COOLER_TWO  = 0;  // cooler_two_slow
  localparam int unsigned SRC1_W         = 7;  // sources below the summary bit

  // status/mask two field positions
  localparam int unsigned B2_OVERHEAT_LIMIT_B     = 5;  // thermistor_b_fault
  localparam int unsigned B2_OVERHEAT_LIMIT_A     = 4;  // thermistor_a_fault
  localparam int unsigned B2_DIODE_ONE   = 3;  // diode_one_fault
  localparam int unsigned B2_DIODE_TWO   = 2;  // diode_two_fault
  localparam int unsigned B2_HOT_TIME    = 1;  // hot_time_exceeded
  localparam int unsigned B2_OVERTEMP    = 0;  // overtemp_limit_flag
  localparam int unsigned SRC2_W         = 6;

  // timer values
  localparam logic [7:0] TMR_FIRST = 8'h01;
  localparam logic [7:0] TMR_FULL  = 8'hff;

  // timing figures
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned HOT_FIRST_MS  = 50;   // first step past the assertion bit
  localparam int unsigned HOT_STEP_MS   = 25;   // weight of one count after that
  localparam int unsigned HOT_FIRST_CYC = HOT_FIRST_MS * (CLK_HZ / 1000);
  localparam int unsigned HOT_STEP_CYC  = HOT_STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W         = 20;   // holds up to the first-step count

endpackage : amht_pkg

// >>> core/amht_core.sv
/*
  alert mask and processor-hot timer: sticky status registers, two mask
  registers, the active-low alert output and the cumulative hot timer
  with its limit compare.
  assumes a serial bus engine that hands one-cycle read and write strobes
  with an 8-bit address, and limit comparators that present level flags
  on the core clock. the hot input arrives asynchronously from a pin.
  the timer steps are counted in core-clock cycles, so both step
  parameters must be rescaled if the core clock changes; the later step
  weight is taken as 25 ms. each strobe must be a one-cycle pulse, since
  every read cycle counts as one clear-on-read. the alert pin is
  registered and trails its status bit by one cycle.
*/
// Summary of operation
// - out-of-limit sets a sticky status bit, cleared by status read after condition clears, or for hot time by timer read
// - alert stays low while unmasked source out of limit, until status read
// - mask bit blocks alert only; status bit still sets normally
// - mask one bits: summary, input one, input two, supply, remote, die, coolers
// - mask two bits: thermistors, diodes, hot-time limit, overtemperature
// - hot timer runs while input asserted, pauses otherwise, accumulates
// - eight-bit hot timer saturates at full scale until read
// - bit0 on first assertion; past 50 ms becomes two, then counts steps
// - reading hot timer returns count then clears it
// - hot timer read clears hot-time-exceeded status bit
// - read during assertion restarts at one; limit zero sets flag again
// - timer strictly above limit sets hot flag and alert unless masked
// - limit zero alerts on first assertion, limit one after 50 ms
// - eight-bit limit spans first assertion to about 6.4 seconds
// - status one bit7 reads one whenever any status two bit set
// - status two bit1 is hot-time exceeded, bit0 overtemperature
`timescale 1ns/1ns

module amht_core #(
  parameter int unsigned P_FIRST_CYC = amht_pkg::HOT_FIRST_CYC,
  parameter int unsigned P_STEP_CYC  = amht_pkg::HOT_STEP_CYC
) (
  // clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_nrst,
  // register access from the serial bus engine
  input  wire logic [amht_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [amht_pkg::DATA_W-1:0]   i_reg_wdata,
  output logic      [amht_pkg::DATA_W-1:0]   o_reg_rdata,
  // out-of-limit levels from the comparators
  input  wire logic [amht_pkg::SRC1_W-1:0]   i_limit_one,
  input  wire logic [amht_pkg::SRC2_W-1:0]   i_limit_two,
  // processor hot pin, active low
  input  wire logic                          i_cpu_overheat_in_n,
  // alert pin, active low
  output logic                               o_alert_n
);

  // synchroniser, filtered level and timer state
  logic [2:0]                        hot_sync_reg;
  logic                              hot_lvl_reg;
  logic [amht_pkg::CNT_W-1:0]        sub_cnt_reg;
  logic [amht_pkg::CNT_W-1:0]        sub_cnt_next;
  logic [7:0]                        timer_reg;
  logic [7:0]                        timer_next;
  logic [7:0]                        limit_reg;
  logic [7:0]                        mask_one_reg;
  logic [7:0]                        mask_two_reg;
  logic [amht_pkg::SRC1_W-1:0]       stat_one_reg;
  logic [amht_pkg::SRC2_W-1:0]       stat_two_reg;
  logic [amht_pkg::SRC2_W-1:0]       src_two;
  logic [amht_pkg::CNT_W-1:0]        step_thr;
  logic                              summary;
  logic                              hot_over;
  // decoded register strobes
  logic                              rd_timer;
  logic                              rd_stat_one;
  logic                              rd_stat_two;
  logic                              wr_mask_one;
  logic                              wr_mask_two;
  logic                              wr_limit;
  // per-bit next values and alert gating
  logic [amht_pkg::SRC1_W-1:0]       stat_one_next;
  logic [amht_pkg::SRC2_W-1:0]       stat_two_next;
  logic [amht_pkg::SRC1_W-1:0]       pend_one;
  logic [amht_pkg::SRC2_W-1:0]       pend_two;
  logic                              alert_one;
  logic                              alert_two;

  // register access decode
  // writes to read-only or unmapped offsets decode to nothing
  assign rd_timer    = i_reg_rd && (i_reg_addr == amht_pkg::OFS_HOT_TIMER);
  assign rd_stat_one = i_reg_rd && (i_reg_addr == amht_pkg::OFS_STATUS_ONE);
  assign rd_stat_two = i_reg_rd && (i_reg_addr == amht_pkg::OFS_STATUS_TWO);
  assign wr_mask_one = i_reg_wr && (i_reg_addr == amht_pkg::OFS_MASK_ONE);
  assign wr_mask_two = i_reg_wr && (i_reg_addr == amht_pkg::OFS_MASK_TWO);
  assign wr_limit    = i_reg_wr && (i_reg_addr == amht_pkg::OFS_HOT_LIMIT);

  // three-stage synchroniser on the hot pin, inverted to active high
  // stage one may go metastable, so only stage two ever reads it
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hot_sync_reg <= 3'h0;
    end
    else
    begin
      hot_sync_reg <= {hot_sync_reg[1:0], ~i_cpu_overheat_in_n};
    end
  end

  // level only moves once stages two and three agree, filtering one-cycle glitches
  // so a one-cycle pin pulse never reaches the timer
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hot_lvl_reg <= 1'b0;
    end
    else if (hot_sync_reg[1] == hot_sync_reg[2])
    begin
      hot_lvl_reg <= hot_sync_reg[2];
    end
  end

  // prescaler length depends on whether the first 50 ms step is still pending
  // the first step is the long one, so the count lands on two at 50 ms
  assign step_thr = (timer_reg == amht_pkg::TMR_FIRST) ?
                    amht_pkg::CNT_W'(P_FIRST_CYC) : amht_pkg::CNT_W'(P_STEP_CYC);

  // timer next state: read clears, else accumulate while asserted
  // the prescaler is kept over a negation, so partial steps carry over
  always_comb
  begin
    timer_next   = timer_reg;
    sub_cnt_next = sub_cnt_reg;
    if (rd_timer)
    begin
      // a read during assertion restarts at one and counts on from zero
      // the prescaler restarts too, so the next step is a full 50 ms
      timer_next   = hot_lvl_reg ? amht_pkg::TMR_FIRST : amht_pkg::RST_TIMER;
      sub_cnt_next = '0;
    end
    else if (hot_lvl_reg)
    begin
      if (timer_reg == amht_pkg::RST_TIMER)
      begin
        timer_next   = amht_pkg::TMR_FIRST;
        sub_cnt_next = '0;
      end
      // full scale holds until a read; the prescaler freezes with it
      else if (timer_reg != amht_pkg::TMR_FULL)
      begin
        if (sub_cnt_reg == step_thr - amht_pkg::CNT_W'(1))
        begin
          // one becomes two (bit1 set, bit0 cleared), then plain counting
          timer_next   = timer_reg + 8'h01;
          sub_cnt_next = '0;
        end
        else
        begin
          sub_cnt_next = sub_cnt_reg + amht_pkg::CNT_W'(1);
        end
      end
    end
    // negated input: both counters simply hold, so time accumulates
  end

  // timer and prescaler registers
  // both clear on reset only; reads act through the next-state logic
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      timer_reg   <= amht_pkg::RST_TIMER;
      sub_cnt_reg <= '0;
    end
    else
    begin
      timer_reg   <= timer_next;
      sub_cnt_reg <= sub_cnt_next;
    end
  end

  // host-written limit and masks
  // a new limit acts on the next compare, no re-arming needed
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      limit_reg    <= amht_pkg::RST_LIMIT;
      mask_one_reg <= amht_pkg::RST_MASK;
      mask_two_reg <= amht_pkg::RST_MASK;
    end
    else
    begin
      if (wr_limit)
      begin
        limit_reg <= i_reg_wdata;
      end
      if (wr_mask_one)
      begin
        mask_one_reg <= i_reg_wdata;
      end
      if (wr_mask_two)
      begin
        // upper two bits have no source, kept at zero
        mask_two_reg <= {2'b00, i_reg_wdata[amht_pkg::SRC2_W-1:0]};
      end
    end
  end

  // strict compare: limit zero fires at count one, limit one past 50 ms
  // the compare is live, so lowering the limit can raise the flag at once
  assign hot_over = (timer_reg > limit_reg);

  // second-register sources, hot-time bit fed internally
  always_comb
  begin
    src_two                        = i_limit_two;
    src_two[amht_pkg::B2_HOT_TIME] = hot_over;
  end

  // sticky status one, one gate per source: a read reloads the live level,
  // so set wins and a read clears only bits whose source is gone
  generate
    for (genvar gi = 0; gi < amht_pkg::SRC1_W; gi++)
    begin : g_stat_one
      assign stat_one_next[gi] = rd_stat_one ? i_limit_one[gi] :
                                 (stat_one_reg[gi] | i_limit_one[gi]);
    end
  endgenerate

  // status one register
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stat_one_reg <= amht_pkg::RST_STATUS[amht_pkg::SRC1_W-1:0];
    end
    else
    begin
      stat_one_reg <= stat_one_next;
    end
  end

  // sticky status two, one gate per source; a timer read clears the
  // hot-time bit outright, since the compare still sees the old count
  // this cycle, so the clear must win; a limit of zero under assertion
  // sets the bit again one cycle later
  generate
    for (genvar gj = 0; gj < amht_pkg::SRC2_W; gj++)
    begin : g_stat_two
      if (gj == amht_pkg::B2_HOT_TIME)
      begin : g_hot
        assign stat_two_next[gj] = rd_timer    ? 1'b0 :
                                   rd_stat_two ? src_two[gj] :
                                   (stat_two_reg[gj] | src_two[gj]);
      end
      else
      begin : g_src
        assign stat_two_next[gj] = rd_stat_two ? src_two[gj] :
                                   (stat_two_reg[gj] | src_two[gj]);
      end
    end
  endgenerate

  // status two register
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stat_two_reg <= amht_pkg::RST_STATUS[amht_pkg::SRC2_W-1:0];
    end
    else
    begin
      stat_two_reg <= stat_two_next;
    end
  end

  // summary bit is live, not stored,
  // so it drops as soon as status two is read clean
  assign summary = |stat_two_reg;

  // unmasked pending sources of status one; a mask stops only the alert
  generate
    for (genvar gk = 0; gk < amht_pkg::SRC1_W; gk++)
    begin : g_pend_one
      assign pend_one[gk] = stat_one_reg[gk] & ~mask_one_reg[gk];
    end
  endgenerate

  // unmasked pending sources of status two
  generate
    for (genvar gm = 0; gm < amht_pkg::SRC2_W; gm++)
    begin : g_pend_two
      assign pend_two[gm] = stat_two_reg[gm] & ~mask_two_reg[gm];
    end
  endgenerate

  // second register reaches the pin only through the summary mask
  assign alert_one = |pend_one;
  assign alert_two = ~mask_one_reg[amht_pkg::B1_SUMMARY] && (|pend_two);

  // alert pin, registered so it cannot glitch on the board
  // the extra cycle of latency is the price of a clean edge
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_alert_n <= 1'b1;
    end
    else
    begin
      o_alert_n <= ~(alert_one | alert_two);
    end
  end

  // read data captured on the strobe, before any clear-on-read takes effect
  // unmapped offsets read as zero
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_reg_rdata <= amht_pkg::RD_UNMAPPED;
    end
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        amht_pkg::OFS_HOT_TIMER:  o_reg_rdata <= timer_reg;
        amht_pkg::OFS_STATUS_ONE: o_reg_rdata <= {summary, stat_one_reg};
        amht_pkg::OFS_STATUS_TWO: o_reg_rdata <= {2'b00, stat_two_reg};
        amht_pkg::OFS_MASK_ONE:   o_reg_rdata <= mask_one_reg;
        amht_pkg::OFS_MASK_TWO:   o_reg_rdata <= mask_two_reg;
        amht_pkg::OFS_HOT_LIMIT:  o_reg_rdata <= limit_reg;
        default:                  o_reg_rdata <= amht_pkg::RD_UNMAPPED;
      endcase
    end
  end

endmodule : amht_core

// >>> verif/amht_chk.sv
/* port checker for amht_core: status, alert and hot timer relations.
   assumes the source levels stay low while reset is held */
`timescale 1ns/1ns
module amht_chk (
  // clock, reset and register strobes
  input wire logic       i_mclk,
  input wire logic       i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // sources, hot pin and alert
  input wire logic [6:0] i_limit_one,
  input wire logic [5:0] i_limit_two,
  input wire logic       i_cpu_overheat_in_n,
  input wire logic       o_alert_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  logic [7:0] m1_reg;
  // read decodes
  wire logic rt = i_reg_rd && i_reg_addr == 8'h0f;
  wire logic r1 = i_reg_rd && i_reg_addr == 8'h10;
  wire logic r2 = i_reg_rd && i_reg_addr == 8'h11;
  // mask shadow, follows host writes so alert can be predicted
  always_ff @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      m1_reg <= 8'h00;
    else if (i_reg_wr && i_reg_addr == 8'h12)
      m1_reg <= i_reg_wdata;
  property p_stick;
    r1 |=> (o_reg_rdata[6:0] & $past(i_limit_one, 2)) == $past(i_limit_one, 2);
  endproperty
  a_stick: assert property (p_stick) else $error("status lost");
  property p_alert;
    |(i_limit_one & ~m1_reg[6:0]) |=> ##1 !o_alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing");
  property p_mask;
    $past(m1_reg) == 8'hff |-> o_alert_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alert");
  property p_rel;
    $rose(i_nrst) |-> o_alert_n;
  endproperty
  a_rel: assert property (p_rel) else $error("alert after reset");
  property p_tclr;
    i_cpu_overheat_in_n [*5] ##0 rt ##4 rt |=> o_reg_rdata == 8'h00;
  endproperty
  a_tclr: assert property (p_tclr) else $error("timer kept");
  property p_trst;
    (!i_cpu_overheat_in_n) [*5] ##0 rt ##2 rt |=> o_reg_rdata == 8'h01;
  endproperty
  a_trst: assert property (p_trst) else $error("no restart");
  property p_hclr;
    i_cpu_overheat_in_n [*5] ##0 rt ##2 r2 |=> !o_reg_rdata[1];
  endproperty
  a_hclr: assert property (p_hclr) else $error("hot flag kept");
  property p_sum;
    r1 && $past(i_limit_two[0]) |=> o_reg_rdata[7];
  endproperty
  a_sum: assert property (p_sum) else $error("summary low");
  // main scenarios reached
  cover property (rt && !i_cpu_overheat_in_n);
  cover property ($fell(o_alert_n));
  cover property ($rose(o_alert_n));
endmodule : amht_chk
bind amht_core amht_chk i_chk (.*);

// >>> verif/amht_host.sv
/* host model: register strobes and processor hot pin.
   assumes the core samples everything on the rising edge */
`timescale 1ns/1ns
module amht_host (
  // clock and read data
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_rdata,
  // strobes and hot pin
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  output logic            o_hot_n
);
  // idle bus, hot pin negated
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_hot_n = 1'b1;
  end
  // one strobe cycle; data inverted once released so stale values show
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = !w;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~d;
    q = i_rdata;
  endtask : acc
  // hot pin level, changed off the sampling edge
  task automatic hot(input logic v);
    @(negedge i_mclk);
    o_hot_n = v;
  endtask : hot
endmodule : amht_host

// >>> verif/amht_tb.sv
/* self-checking bench for amht_core with the host model.
   assumes short timer steps of 20 and 10 cycles */
`timescale 1ns/1ns
module tb;
  logic       i_mclk = 1'b0;
  logic       i_nrst = 1'b0;
  logic [6:0] lim1 = 7'h00;
  logic [5:0] lim2 = 6'h00;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       hot_n;
  logic       alert_n;
  int         fails = 0;
  int         total_checks = 0;
  // 10 MHz core clock
  always #50 i_mclk = ~i_mclk;
  // short steps keep saturation within a few thousand cycles
  amht_core #(.P_FIRST_CYC(20), .P_STEP_CYC(10)) i_dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_limit_one(lim1), .i_limit_two(lim2),
    .i_cpu_overheat_in_n(hot_n), .o_alert_n(alert_n));
  amht_host i_host (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_hot_n(hot_n));
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic ach(input logic e);
    chk("alert_n", {7'h00, e}, {7'h00, alert_n});
  endtask : ach
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.acc(1'b1, a, d, q);
  endtask : wr_reg
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    i_host.acc(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rc
  // one-cycle source pulse, then give status and alert time to land
  task automatic pulse1(input logic [6:0] v);
    lim1 = v;
    cyc(1);
    lim1 = 7'h00;
    cyc(3);
  endtask : pulse1
  task automatic t_basic();
    ach(1'b1);
    rc(8'h12, 8'h00);
    rc(8'h0f, 8'h00);
    i_host.hot(1'b0);
    i_host.hot(1'b1);
    cyc(6);
    rc(8'h0f, 8'h00);
    rc(8'h20, 8'h00);
    wr_reg(8'h12, 8'ha5);
    wr_reg(8'h13, 8'hff);
    wr_reg(8'h10, 8'hff);
    rc(8'h12, 8'ha5);
    rc(8'h13, 8'h3f);
    rc(8'h10, 8'h00);
    wr_reg(8'h12, 8'h00);
    wr_reg(8'h13, 8'h00);
  endtask : t_basic
  task automatic t_sticky();
    pulse1(7'h08);
    ach(1'b0);
    rc(8'h10, 8'h08);
    cyc(2);
    ach(1'b1);
    lim1 = 7'h40;
    cyc(3);
    rc(8'h10, 8'h40);
    lim1 = 7'h00;
    rc(8'h10, 8'h40);
    rc(8'h10, 8'h00);
  endtask : t_sticky
  task automatic t_masked();
    wr_reg(8'h12, 8'hff);
    pulse1(7'h04);
    ach(1'b1);
    rc(8'h10, 8'h04);
    rc(8'h10, 8'h00);
    wr_reg(8'h12, 8'h00);
    wr_reg(8'h13, 8'h01);
    lim2 = 6'h01;
    cyc(4);
    lim2 = 6'h00;
    ach(1'b1);
    rc(8'h10, 8'h80);
    rc(8'h11, 8'h01);
    rc(8'h10, 8'h00);
    wr_reg(8'h13, 8'h00);
    lim2 = 6'h3c;
    cyc(3);
    lim2 = 6'h00;
    ach(1'b0);
    rc(8'h11, 8'h3c);
    pulse1(7'h33);
    ach(1'b0);
    rc(8'h10, 8'h33);
  endtask : t_masked
  // two hot bursts add up past the first step, limit one
  task automatic t_hot();
    wr_reg(8'h1e, 8'h01);
    rc(8'h1e, 8'h01);
    i_host.hot(1'b0);
    cyc(8);
    i_host.hot(1'b1);
    cyc(2);
    ach(1'b1);
    i_host.hot(1'b0);
    cyc(15);
    i_host.hot(1'b1);
    cyc(5);
    ach(1'b0);
    rc(8'h11, 8'h02);
    rc(8'h0f, 8'h02);
    rc(8'h11, 8'h00);
    rc(8'h0f, 8'h00);
  endtask : t_hot
  task automatic t_sat();
    wr_reg(8'h1e, 8'h00);
    i_host.hot(1'b0);
    cyc(2700);
    rc(8'h0f, 8'hff);
    rc(8'h0f, 8'h01);
    rc(8'h11, 8'h02);
    i_host.hot(1'b1);
  endtask : t_sat
  task automatic wrap_up();
    if (fails == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // reset for four cycles, then the scenarios
  initial
  begin
    cyc(4);
    i_nrst = 1'b1;
    t_basic();
    t_sticky();
    t_masked();
    t_hot();
    t_sat();
    wrap_up();
  end
  // about 2850 cycles expected; cut a hang at 10000
  initial
  begin
    #1_000_000;
    fails++;
    wrap_up();
  end
endmodule : tb
